// *** common/loop_cfg_map.vh ***
`ifndef LOOP_CFG_MAP_VH
`define LOOP_CFG_MAP_VH
// Register indices (16-bit word registers)
`define ADDR_LOOP_CTRL     9'h171
`define ADDR_LOOP_INT      9'h172
`define ADDR_LOOP_NUM      9'h173
`define ADDR_LOOP_DEN      9'h174
`define ADDR_LOOP_RATIO    9'h175
`define ADDR_LOOP_REF      9'h176
`define ADDR_LOOP_GAIN     9'h179
`define ADDR_SYNC_EN       9'h181
`define ADDR_SYNC_INT      9'h182
`define ADDR_SYNC_NUM      9'h183
`define ADDR_SYNC_DEN      9'h184
`define ADDR_SYNC_RATIO    9'h185
`define ADDR_SYNC_REF      9'h186
`define ADDR_SYNC_GAIN     9'h187
// Field positions
`define BIT_ENABLE         0
`define BIT_FREERUN        1
`define BIT_UPDATE         15
`define BIT_BANDWIDTH      0
`define F_INT_HI           9
`define F_INT_LO           0
`define F_WORD_HI          15
`define F_WORD_LO          0
`define F_RATIO_HI         11
`define F_RATIO_LO         8
`define F_SRATIO_HI        10
`define F_SRATIO_LO        8
`define F_OUTDIV_HI        3
`define F_OUTDIV_LO        1
`define F_PREDIV_HI        7
`define F_PREDIV_LO        6
`define F_SRC_HI           3
`define F_SRC_LO           0
`define F_GAIN_HI          5
`define F_GAIN_LO          2
// Reset values
`define RST_INT            10'h008
`define RST_SYNC_INT       10'h000
`define RST_NUM            16'h0018
`define RST_DEN            16'h007D
`define RST_SYNC_WORD      16'h0000
`define RST_OUTDIV         3'h3
`define RST_RATIO          4'h0
`define RST_SRATIO         3'h0
`define RST_PREDIV         2'h0
`define RST_SRC            4'h0
`define RST_GAIN           4'h0
`define RST_FREERUN        1'h1
`define RST_ENABLE         1'h0
`define RST_BANDWIDTH      1'h1
// Decode constants
`define OUTDIV_MIN_CODE    3'h2
`define GAIN_SAT_CODE      4'h8
`define GAIN_SAT_SHIFT     4'h8
`define SRC_MASTER_CLOCK_PIN_ONE          4'h0
`define SRC_MASTER_CLOCK_PIN_TWO          4'h1
`define SRC_SERIAL         4'h3
`define SRC_LOOP_A         4'h4
`define SRC_LOOP_B         4'h5
`define SRC_AUDIO_MIN      4'h8
`endif

// *** design/fll_config_registers.v ***
`timescale 1ns/1ns
`default_nettype none
`include "loop_cfg_map.vh"

// Behaviour
// R1 - While enabled, integer and numerator writes wait for the update bit.
// R2 - While disabled, integer and numerator writes take effect at once.
// R3 - Update bit is write-one-to-apply, honoured only with loop enabled.
// R4 - Feedback ratio at bits 11:8 of ratio register, divide value plus one.
// R5 - Output divider bits 3:1 divides by 2..7; codes 0,1 reserved; reset 3.
// R6 - Pre-divider fields bits 7:6 divide by 1,2,4,8.
// R7 - Source selects bits 3:0 decode clocks; unlisted codes reserved.
// R8 - Gain fields bits 5:2 give two to the code, saturating at 256.
// R9 - Sync ratio bits 10:8 divide by 1,2,4,8, any 1XX gives 16.
// R10 - Integer fields 10 bits; numerator and denominator 16 bits.
// R11 - Software sets loop enable last after other configuration.
// R12 - Software sets sync enable last after sync configuration.
// R13 - With sync enabled, main denominator ignored; numerator is K*65536.
// R14 - With sync disabled, numerator below denominator and co-prime.
// R15 - Software picks main ratio and gain from reference frequency.
// R16 - Software picks sync bandwidth by the 128kHz input boundary.
// R17 - Software keeps divided reference below the ratio-dependent maximum.
// R18 - Software avoids integer overall multiplier using odd ratios.
// R19 - Free-running bit 1 of control register, resets to one.
// R20 - Sync bandwidth bit 0: zero wide, one narrow; resets to one.
// R21 - Update bit reads zero and gives a one-cycle apply pulse.
module fll_config_registers #(
   parameter ADDR_W = 9,
   parameter DATA_W = 16
) (
   // Clock and reset
   input  wire              clock,
   input  wire              reset,
   // Register port
   input  wire [ADDR_W-1:0] reg_addr,
   input  wire [DATA_W-1:0] reg_wdata,
   input  wire              reg_write,
   input  wire              reg_read,
   output reg  [DATA_W-1:0] reg_rdata,
   // Main loop settings to the core
   output wire              loop_enable,
   output wire              free_running_enable,
   output wire [9:0]        integer_multiplier,
   output wire [15:0]       fraction_numerator,
   output wire [15:0]       fraction_denominator,
   output wire              fraction_denominator_used,
   output wire [3:0]        feedback_ratio,
   output reg  [4:0]        feedback_divide,
   output wire [2:0]        output_divider,
   output reg  [2:0]        output_divide,
   output wire              output_divider_reserved,
   output wire [1:0]        main_ref_prediv,
   output reg  [3:0]        main_prediv_factor,
   output wire [3:0]        main_ref_select,
   output reg               main_ref_reserved,
   output wire [3:0]        main_loop_gain,
   output reg  [3:0]        main_gain_shift,
   output reg               apply_multiplier_update,
   // Synchroniser settings to the core
   output wire              sync_path_enable,
   output wire [9:0]        sync_integer_multiplier,
   output wire [15:0]       sync_fraction_numerator,
   output wire [15:0]       sync_fraction_denominator,
   output wire [2:0]        sync_feedback_ratio,
   output reg  [4:0]        sync_feedback_divide,
   output wire [1:0]        sync_ref_prediv,
   output reg  [3:0]        sync_prediv_factor,
   output wire [3:0]        sync_ref_select,
   output reg               sync_ref_reserved,
   output wire [3:0]        sync_loop_gain,
   output reg  [3:0]        sync_gain_shift,
   output wire              sync_bandwidth_select
);

   // Software-visible fields
   reg        enable_q;
   reg        freerun_q;
   reg [9:0]  int_shadow_q;
   reg [15:0] num_shadow_q;
   reg [15:0] den_q;
   reg [3:0]  ratio_q;
   reg [2:0]  outdiv_q;
   reg [1:0]  prediv_q;
   reg [3:0]  src_q;
   reg [3:0]  gain_q;

   // Synchroniser fields
   reg        s_enable_q;
   reg [9:0]  s_int_q;
   reg [15:0] s_num_q;
   reg [15:0] s_den_q;
   reg [2:0]  s_ratio_q;
   reg [1:0]  s_prediv_q;
   reg [3:0]  s_src_q;
   reg [3:0]  s_gain_q;
   reg        s_bw_q;
   // Values the core actually runs on
   reg [9:0]  int_live_q;
   reg [15:0] num_live_q;

   // Write decodes for the deferred pair
   wire wr_int = reg_write && (reg_addr == `ADDR_LOOP_INT);
   wire wr_num = reg_write && (reg_addr == `ADDR_LOOP_NUM);
   // Update only counts while the loop runs; ignored otherwise
   wire upd_hit = wr_int && reg_wdata[`BIT_UPDATE] && enable_q; // [R3]

   // Register writes
   always @(posedge clock) begin
      if (reset) begin
         enable_q     <= `RST_ENABLE;
         freerun_q    <= `RST_FREERUN;                  // [R19]
         int_shadow_q <= `RST_INT;
         num_shadow_q <= `RST_NUM;
         den_q        <= `RST_DEN;
         ratio_q      <= `RST_RATIO;
         outdiv_q     <= `RST_OUTDIV;                   // [R5]
         prediv_q     <= `RST_PREDIV;
         src_q        <= `RST_SRC;
         gain_q       <= `RST_GAIN;
         // Synchroniser side
         s_enable_q   <= `RST_ENABLE;
         s_int_q      <= `RST_SYNC_INT;
         s_num_q      <= `RST_SYNC_WORD;
         s_den_q      <= `RST_SYNC_WORD;
         s_ratio_q    <= `RST_SRATIO;
         s_prediv_q   <= `RST_PREDIV;
         s_src_q      <= `RST_SRC;
         s_gain_q     <= `RST_GAIN;
         s_bw_q       <= `RST_BANDWIDTH;                // [R20]
      end else if (reg_write) begin
         case (reg_addr)
            // Main loop enable and free-run mode
            `ADDR_LOOP_CTRL: begin
               enable_q  <= reg_wdata[`BIT_ENABLE];
               freerun_q <= reg_wdata[`BIT_FREERUN];    // [R19]
            end

            // Pending integer; the update bit is never kept
            `ADDR_LOOP_INT:
               int_shadow_q <= reg_wdata[`F_INT_HI:`F_INT_LO]; // [R10]

            // Pending numerator, applied by the update
            `ADDR_LOOP_NUM:
               num_shadow_q <= reg_wdata[`F_WORD_HI:`F_WORD_LO]; // [R10]

            // Denominator is never deferred
            `ADDR_LOOP_DEN:
               den_q <= reg_wdata[`F_WORD_HI:`F_WORD_LO];

            // Feedback ratio and output divider share a word
            `ADDR_LOOP_RATIO: begin
               ratio_q  <= reg_wdata[`F_RATIO_HI:`F_RATIO_LO]; // [R4]
               outdiv_q <= reg_wdata[`F_OUTDIV_HI:`F_OUTDIV_LO]; // [R5]
            end

            // Main reference divider and source
            `ADDR_LOOP_REF: begin
               prediv_q <= reg_wdata[`F_PREDIV_HI:`F_PREDIV_LO]; // [R6]
               src_q    <= reg_wdata[`F_SRC_HI:`F_SRC_LO];       // [R7]
            end

            `ADDR_LOOP_GAIN:
               gain_q <= reg_wdata[`F_GAIN_HI:`F_GAIN_LO];       // [R8]

            // Synchroniser enable; software sets it last
            `ADDR_SYNC_EN:
               s_enable_q <= reg_wdata[`BIT_ENABLE];

            `ADDR_SYNC_INT:
               s_int_q <= reg_wdata[`F_INT_HI:`F_INT_LO];

            `ADDR_SYNC_NUM:
               s_num_q <= reg_wdata[`F_WORD_HI:`F_WORD_LO];

            `ADDR_SYNC_DEN:
               s_den_q <= reg_wdata[`F_WORD_HI:`F_WORD_LO];

            // Sync ratio uses its own coding
            `ADDR_SYNC_RATIO:
               s_ratio_q <= reg_wdata[`F_SRATIO_HI:`F_SRATIO_LO]; // [R9]

            `ADDR_SYNC_REF: begin
               s_prediv_q <= reg_wdata[`F_PREDIV_HI:`F_PREDIV_LO];
               s_src_q    <= reg_wdata[`F_SRC_HI:`F_SRC_LO];
            end

            // Gain and bandwidth share a word
            `ADDR_SYNC_GAIN: begin
               s_gain_q <= reg_wdata[`F_GAIN_HI:`F_GAIN_LO];
               s_bw_q   <= reg_wdata[`BIT_BANDWIDTH];           // [R20]
            end

            // Unmapped addresses are ignored
            default: ;
         endcase
      end
   end

   // Live multiplier: follows writes while off, waits for update while on.
   // The update carries the integer from the same write, so one write can
   // change the integer and apply both at once.
   always @(posedge clock) begin
      if (reset) begin
         int_live_q              <= `RST_INT;
         num_live_q              <= `RST_NUM;
         apply_multiplier_update <= 1'b0;
      end else begin
         // One-cycle pulse; the bit itself is never stored
         apply_multiplier_update <= upd_hit;                    // [R21]

         // Shadow and live move together while off
         if (!enable_q) begin
            if (wr_int)
               int_live_q <= reg_wdata[`F_INT_HI:`F_INT_LO];    // [R2]
            if (wr_num)
               num_live_q <= reg_wdata[`F_WORD_HI:`F_WORD_LO];  // [R2]
         end else if (upd_hit) begin
            // Numerator comes from the pending copy, so a value
            // written before the update rides along with it
            int_live_q <= reg_wdata[`F_INT_HI:`F_INT_LO];       // [R1]
            num_live_q <= num_shadow_q;                         // [R1]
         end
      end
   end

   // Read path, data one cycle after the strobe
   always @(posedge clock) begin
      if (reset) begin
         reg_rdata <= {DATA_W{1'b0}};
      end else if (reg_read) begin
         reg_rdata <= {DATA_W{1'b0}};
         // Clear first so reserved bits read zero
         case (reg_addr)
            `ADDR_LOOP_CTRL: begin
               reg_rdata[`BIT_ENABLE]  <= enable_q;
               reg_rdata[`BIT_FREERUN] <= freerun_q;
            end

            // Update bit never stored, reads as zero
            `ADDR_LOOP_INT:
               reg_rdata[`F_INT_HI:`F_INT_LO] <= int_shadow_q;  // [R21]

            `ADDR_LOOP_NUM:
               reg_rdata[`F_WORD_HI:`F_WORD_LO] <= num_shadow_q;

            `ADDR_LOOP_DEN:
               reg_rdata[`F_WORD_HI:`F_WORD_LO] <= den_q;

            `ADDR_LOOP_RATIO: begin
               reg_rdata[`F_RATIO_HI:`F_RATIO_LO]   <= ratio_q;
               reg_rdata[`F_OUTDIV_HI:`F_OUTDIV_LO] <= outdiv_q;
            end

            `ADDR_LOOP_REF: begin
               reg_rdata[`F_PREDIV_HI:`F_PREDIV_LO] <= prediv_q;
               reg_rdata[`F_SRC_HI:`F_SRC_LO]       <= src_q;
            end

            `ADDR_LOOP_GAIN:
               reg_rdata[`F_GAIN_HI:`F_GAIN_LO] <= gain_q;

            // Synchroniser registers
            `ADDR_SYNC_EN:
               reg_rdata[`BIT_ENABLE] <= s_enable_q;

            `ADDR_SYNC_INT:
               reg_rdata[`F_INT_HI:`F_INT_LO] <= s_int_q;

            `ADDR_SYNC_NUM:
               reg_rdata[`F_WORD_HI:`F_WORD_LO] <= s_num_q;

            `ADDR_SYNC_DEN:
               reg_rdata[`F_WORD_HI:`F_WORD_LO] <= s_den_q;

            `ADDR_SYNC_RATIO:
               reg_rdata[`F_SRATIO_HI:`F_SRATIO_LO] <= s_ratio_q;

            `ADDR_SYNC_REF: begin
               reg_rdata[`F_PREDIV_HI:`F_PREDIV_LO] <= s_prediv_q;
               reg_rdata[`F_SRC_HI:`F_SRC_LO]       <= s_src_q;
            end

            `ADDR_SYNC_GAIN: begin
               reg_rdata[`F_GAIN_HI:`F_GAIN_LO] <= s_gain_q;
               reg_rdata[`BIT_BANDWIDTH]        <= s_bw_q;
            end

            // Unmapped addresses read zero
            default: ;
         endcase
      end
   end

   // Raw fields to the core
   assign loop_enable               = enable_q;
   assign free_running_enable       = freerun_q;
   assign integer_multiplier        = int_live_q;
   assign fraction_numerator        = num_live_q;
   assign fraction_denominator      = den_q;
   // Denominator is meaningless when the sync path sets the fraction
   assign fraction_denominator_used = ~s_enable_q;               // [R13]
   assign feedback_ratio            = ratio_q;
   assign output_divider            = outdiv_q;
   assign output_divider_reserved   = (outdiv_q < `OUTDIV_MIN_CODE); // [R5]
   assign main_ref_prediv           = prediv_q;
   assign main_ref_select           = src_q;
   assign main_loop_gain            = gain_q;

   // Synchroniser fields to the core
   assign sync_path_enable          = s_enable_q;
   assign sync_integer_multiplier   = s_int_q;
   assign sync_fraction_numerator   = s_num_q;
   assign sync_fraction_denominator = s_den_q;
   assign sync_feedback_ratio       = s_ratio_q;
   assign sync_ref_prediv           = s_prediv_q;
   assign sync_ref_select           = s_src_q;
   assign sync_loop_gain            = s_gain_q;
   assign sync_bandwidth_select     = s_bw_q;

   // Source code validity: audio clocks are 1000 and up
   // Reserved codes still reach the core; the flag lets it hold off
   function src_bad;
      input [3:0] code;
      begin
         src_bad = !((code == `SRC_MASTER_CLOCK_PIN_ONE) || (code == `SRC_MASTER_CLOCK_PIN_TWO) ||
                     (code == `SRC_SERIAL) || (code == `SRC_LOOP_A) ||
                     (code == `SRC_LOOP_B) || (code >= `SRC_AUDIO_MIN));
      end
   endfunction

   // Gain exponent, saturating at eight (x256)
   // Every code from 8 upwards means the same gain
   function [3:0] gain_exp;
      input [3:0] code;
      begin
         if (code >= `GAIN_SAT_CODE)
            gain_exp = `GAIN_SAT_SHIFT;
         else
            gain_exp = code;
      end
   endfunction

   // Decoded divide factors, source reserved flags and gain shifts for the core
   always @(posedge clock) begin
      if (reset) begin
         // Decodes of the reset field values
         feedback_divide      <= 5'h01;
         output_divide        <= `RST_OUTDIV;
         main_prediv_factor   <= 4'h1;
         sync_prediv_factor   <= 4'h1;
         main_ref_reserved    <= 1'b0;
         sync_ref_reserved    <= 1'b0;
         main_gain_shift      <= 4'h0;
         sync_gain_shift      <= 4'h0;
         sync_feedback_divide <= 5'h01;
      end else begin
         feedback_divide    <= {1'b0, ratio_q} + 5'h01;          // [R4]
         output_divide      <= outdiv_q;                         // [R5]
         main_prediv_factor <= 4'h1 << prediv_q;                 // [R6]
         sync_prediv_factor <= 4'h1 << s_prediv_q;               // [R6]
         main_ref_reserved  <= src_bad(src_q);                   // [R7]
         sync_ref_reserved  <= src_bad(s_src_q);                 // [R7]
         main_gain_shift    <= gain_exp(gain_q);                 // [R8]
         sync_gain_shift    <= gain_exp(s_gain_q);               // [R8]
         // Sync ratio coding differs from the main one
         if (s_ratio_q[2])
            sync_feedback_divide <= 5'h10;                       // [R9]
         else
            sync_feedback_divide <= 5'h01 << s_ratio_q[1:0];     // [R9]
      end
   end

endmodule // fll_config_registers
`default_nettype wire

// *** bench/fll_config_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module fll_config_properties (
   // Clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // Register port
   input wire logic [8:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [15:0] reg_rdata,
   // Loop settings
   input wire logic        loop_enable,
   input wire logic [9:0]  integer_multiplier,
   input wire logic [15:0] fraction_numerator,
   input wire logic        fraction_denominator_used,
   input wire logic        sync_path_enable,
   input wire logic [3:0]  feedback_ratio,
   input wire logic [4:0]  feedback_divide,
   input wire logic [2:0]  output_divider,
   input wire logic        output_divider_reserved,
   input wire logic [3:0]  main_loop_gain,
   input wire logic [3:0]  main_gain_shift,
   input wire logic [2:0]  sync_feedback_ratio,
   input wire logic [4:0]  sync_feedback_divide,
   input wire logic        apply_multiplier_update
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [15:0] wd_q;
   logic [3:0]  fr_q, gn_q;
   logic [2:0]  sr_q;
   logic        upd_q;
   wire logic   int_wr = reg_write && reg_addr == 9'h172;
   wire logic   num_wr = reg_write && reg_addr == 9'h173;
   // Copies from one edge back, since the decodes lag their fields
   always_ff @(posedge clock) begin
      wd_q  <= reg_wdata;
      fr_q  <= feedback_ratio;
      gn_q  <= main_loop_gain;
      sr_q  <= sync_feedback_ratio;
      upd_q <= int_wr && reg_wdata[15] && loop_enable;
   end
   pulse_cause_a: assert property (apply_multiplier_update == upd_q)
      else $error("apply pulse without honoured update");
   upd_apply_a: assert property (upd_q |-> integer_multiplier == wd_q[9:0])
      else $error("update did not apply integer");
   int_hold_a: assert property (loop_enable && int_wr && !reg_wdata[15]
      |=> $stable(integer_multiplier)) else $error("integer moved early");
   num_hold_a: assert property (loop_enable && num_wr
      |=> $stable(fraction_numerator)) else $error("numerator moved early");
   int_direct_a: assert property (!loop_enable && int_wr
      |=> integer_multiplier == wd_q[9:0]) else $error("integer not direct");
   num_direct_a: assert property (!loop_enable && num_wr
      |=> fraction_numerator == wd_q) else $error("numerator not direct");
   upd_reads_zero_a: assert property (reg_read && reg_addr == 9'h172
      |=> !reg_rdata[15]) else $error("update bit read back");
   ratio_div_a: assert property (feedback_divide == {1'b0, fr_q} + 5'h01)
      else $error("feedback divide wrong");
   gain_shift_a: assert property (main_gain_shift == (gn_q[3] ? 4'h8 : gn_q))
      else $error("gain shift wrong");
   sync_div_a: assert property (sync_feedback_divide ==
      (sr_q[2] ? 5'h10 : 5'h01 << sr_q[1:0])) else $error("sync divide wrong");
   outdiv_rsv_a: assert property (output_divider_reserved ==
      (output_divider < 3'h2)) else $error("reserved divider flag wrong");
   den_used_a: assert property (fraction_denominator_used == !sync_path_enable)
      else $error("denominator use flag wrong");
endmodule // fll_config_properties
`default_nettype wire

// *** bench/fll_config_registers_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module fll_config_registers_test;
   // Driven ports
   logic clock, reset, reg_write, reg_read;
   logic [8:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv;
   // Observed outputs
   logic loop_enable, free_running_enable, fraction_denominator_used;
   logic output_divider_reserved, main_ref_reserved, apply_multiplier_update;
   logic sync_path_enable, sync_ref_reserved, sync_bandwidth_select;
   logic [9:0] integer_multiplier, sync_integer_multiplier;
   logic [15:0] fraction_numerator, fraction_denominator;
   logic [15:0] sync_fraction_numerator, sync_fraction_denominator;
   logic [4:0] feedback_divide, sync_feedback_divide, i;
   logic [3:0] feedback_ratio, main_prediv_factor, main_ref_select;
   logic [3:0] main_loop_gain, main_gain_shift, sync_prediv_factor;
   logic [3:0] sync_ref_select, sync_loop_gain, sync_gain_shift;
   logic [2:0] output_divider, output_divide, sync_feedback_ratio;
   logic [1:0] main_ref_prediv, sync_ref_prediv;
   int num_errors = 0, n_compared = 0;
   // Address, reset value and writable mask; last entry is unmapped
   localparam logic [8:0] ADR [15] = '{9'h171, 9'h172, 9'h173, 9'h174,
      9'h175, 9'h176, 9'h179, 9'h181, 9'h182, 9'h183, 9'h184, 9'h185,
      9'h186, 9'h187, 9'h177};
   localparam logic [15:0] RST [15] = '{16'h0002, 16'h0008, 16'h0018,
      16'h007D, 16'h0006, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000};
   localparam logic [15:0] MSK [15] = '{16'h0003, 16'h03FF, 16'hFFFF,
      16'hFFFF, 16'h0F0E, 16'h00CF, 16'h003C, 16'h0001, 16'h03FF,
      16'hFFFF, 16'hFFFF, 16'h0700, 16'h00CF, 16'h003D, 16'h0000};
   fll_config_registers i_dut (.clock(clock), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .loop_enable(loop_enable),
      .free_running_enable(free_running_enable),
      .integer_multiplier(integer_multiplier),
      .fraction_numerator(fraction_numerator),
      .fraction_denominator(fraction_denominator),
      .fraction_denominator_used(fraction_denominator_used),
      .feedback_ratio(feedback_ratio), .feedback_divide(feedback_divide),
      .output_divider(output_divider), .output_divide(output_divide),
      .output_divider_reserved(output_divider_reserved),
      .main_ref_prediv(main_ref_prediv),
      .main_prediv_factor(main_prediv_factor),
      .main_ref_select(main_ref_select), .main_ref_reserved(main_ref_reserved),
      .main_loop_gain(main_loop_gain), .main_gain_shift(main_gain_shift),
      .apply_multiplier_update(apply_multiplier_update),
      .sync_path_enable(sync_path_enable),
      .sync_integer_multiplier(sync_integer_multiplier),
      .sync_fraction_numerator(sync_fraction_numerator),
      .sync_fraction_denominator(sync_fraction_denominator),
      .sync_feedback_ratio(sync_feedback_ratio),
      .sync_feedback_divide(sync_feedback_divide),
      .sync_ref_prediv(sync_ref_prediv),
      .sync_prediv_factor(sync_prediv_factor),
      .sync_ref_select(sync_ref_select), .sync_ref_reserved(sync_ref_reserved),
      .sync_loop_gain(sync_loop_gain), .sync_gain_shift(sync_gain_shift),
      .sync_bandwidth_select(sync_bandwidth_select));
   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
         num_errors++;
      end
   endtask
   // One-cycle strobes; returns just after the taking edge
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [8:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic do_reset;
      @(posedge clock);
      reset <= 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
   endtask
   // Reset values, then all-ones writes show each writable field
   task automatic s_regs;
      for (int k = 0; k < 15; k++) begin
         rd(ADR[k]);
         chk(rv, RST[k]);
      end
      for (int k = 0; k < 15; k++) wr(ADR[k], 16'hFFFF);
      for (int k = 0; k < 15; k++) begin
         rd(ADR[k]);
         chk(rv, MSK[k]);
      end
   endtask
   // Disabled loop takes values directly; enabled loop defers them
   task automatic s_update;
      chk(fraction_denominator, 16'h007D);
      wr(9'h172, 16'h8123);
      chk(apply_multiplier_update, 16'h0000);
      chk(integer_multiplier, 16'h0123);
      wr(9'h173, 16'h0013);
      chk(fraction_numerator, 16'h0013);
      wr(9'h175, 16'h0006);
      wr(9'h179, 16'h0010);
      wr(9'h176, 16'h0000);
      wr(9'h171, 16'h0001);
      chk(loop_enable, 16'h0001);
      chk(free_running_enable, 16'h0000);
      wr(9'h172, 16'h0055);
      wr(9'h173, 16'h0017);
      chk(integer_multiplier, 16'h0123);
      chk(fraction_numerator, 16'h0013);
      wr(9'h172, 16'h8077);
      chk(apply_multiplier_update, 16'h0001);
      chk(integer_multiplier, 16'h0077);
      chk(fraction_numerator, 16'h0017);
      @(posedge clock);
      #1 chk(apply_multiplier_update, 16'h0000);
      rd(9'h172);
      chk(rv, 16'h0077);
   endtask
   // Every field code through the decoders
   task automatic s_decode;
      for (i = 0; i < 16; i++) begin
         wr(9'h175, {4'h0, i[3:0], 4'h0, i[2:0], 1'b0});
         wr(9'h176, {8'h00, i[1:0], 2'b00, i[3:0]});
         wr(9'h179, {10'h000, i[3:0], 2'b00});
         wr(9'h185, {5'h00, i[2:0], 8'h00});
         wr(9'h186, {8'h00, i[1:0], 2'b00, i[3:0]});
         wr(9'h187, {10'h000, i[3:0], 2'b01});
         @(posedge clock);
         #1 chk(feedback_divide, i + 16'h1);
         chk(output_divider_reserved, i[2:0] < 3'h2);
         if (i[2:0] > 3'h1) chk(output_divide, i[2:0]);
         chk(main_prediv_factor, 16'h1 << i[1:0]);
         chk(sync_prediv_factor, 16'h1 << i[1:0]);
         chk(main_ref_reserved, i == 2 || i == 6 || i == 7);
         chk(sync_ref_reserved, i == 2 || i == 6 || i == 7);
         chk(feedback_ratio, i[3:0]);
         chk(output_divider, i[2:0]);
         chk(main_ref_prediv, i[1:0]);
         chk(sync_ref_prediv, i[1:0]);
         chk(main_ref_select, i[3:0]);
         chk(sync_ref_select, i[3:0]);
         chk(main_loop_gain, i[3:0]);
         chk(sync_loop_gain, i[3:0]);
         chk(sync_feedback_ratio, i[2:0]);
         chk(main_gain_shift, i[3] ? 16'h8 : i);
         chk(sync_gain_shift, i[3] ? 16'h8 : i);
         chk(sync_feedback_divide, i[2] ? 16'h10 : 16'h1 << i[1:0]);
      end
   endtask
   // Denominator use follows the sync enable; bandwidth bit
   task automatic s_sync;
      wr(9'h182, 16'h0155);
      wr(9'h183, 16'h1234);
      wr(9'h184, 16'h4321);
      wr(9'h185, 16'h0000);
      wr(9'h187, 16'h0010);
      chk(sync_integer_multiplier, 16'h0155);
      chk(sync_fraction_numerator, 16'h1234);
      chk(sync_fraction_denominator, 16'h4321);
      chk(sync_bandwidth_select, 16'h0000);
      wr(9'h181, 16'h0001);
      chk(sync_path_enable, 16'h0001);
      chk(fraction_denominator_used, 16'h0000);
      wr(9'h181, 16'h0000);
      chk(fraction_denominator_used, 16'h0001);
   endtask
   task automatic wrap_up;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence; a second reset mid-run clears the all-ones pass
   initial begin
      reset = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 9'h000;
      reg_wdata = 16'h0000;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      s_regs();
      do_reset();
      s_update();
      s_decode();
      s_sync();
      wrap_up();
   end
   // Hang guard, far beyond the expected run length
   initial begin
      #200000;
      num_errors++;
      wrap_up();
   end
endmodule // fll_config_registers_test
bind fll_config_registers fll_config_properties i_chk (.clock(clock),
   .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .loop_enable(loop_enable), .integer_multiplier(integer_multiplier),
   .fraction_numerator(fraction_numerator),
   .fraction_denominator_used(fraction_denominator_used),
   .sync_path_enable(sync_path_enable), .feedback_ratio(feedback_ratio),
   .feedback_divide(feedback_divide), .output_divider(output_divider),
   .output_divider_reserved(output_divider_reserved),
   .main_loop_gain(main_loop_gain), .main_gain_shift(main_gain_shift),
   .sync_feedback_ratio(sync_feedback_ratio),
   .sync_feedback_divide(sync_feedback_divide),
   .apply_multiplier_update(apply_multiplier_update));
`default_nettype wire
